// >>> rtl/sfa_map.svh
// register offsets, opcodes, status bit positions and array layout constants
// included by the package and the device top; definitions only
// Operation
// - capture every command, address and data bit on a rising serial clock edge.
// - change every output bit on a falling serial clock edge.
// - select high deselects the device and floats the serial output.
// - an internal program, erase or status write finishes even when deselected.
// - no command is accepted until select has gone high then low.
// - pause low while selected floats output and ignores clock and input.
// - the write-guard pin blocks status writes only while the lock bit is set, protecting the array with range bits.
// - only clock modes 0 and 3; sample on rising, drive on falling.
// - array of 524,288 bytes, 2048 pages of 256 bytes, linear from zero.
// - programming only clears bits; erase alone sets them back to one.
// - bottom-boot sectors are 4K, 4K, 8K, 16K, 32K, then seven 64K.
// - top-boot sectors are seven 64K, then 32K, 16K, 8K, 4K, 4K.
// - one program writes 1 to 256 bytes, wrapping inside one page.
// - write-armed flag clears at reset and on completing any modifying command.
// - modifying commands run only if the clock count is a multiple of eight.
// - three protect-range bits select the area shielded from program and erase.
// - lock bit plus active write-guard make the lock and range bits read-only.
`ifndef SFA_MAP_SVH
`define SFA_MAP_SVH

`define SFA_ADDR_W     19
`define SFA_PAGE_BYTES 256
`define SFA_PAGE_MASK  19'h000ff
`define SFA_LAST_ADDR  19'h7ffff
`define SFA_ERASED     8'hff
`define SFA_ADDR_BYTES 4'h4
`define SFA_PROG_MIN   4'h5
`define SFA_SRW_BYTES  4'h2
`define SFA_ONE_BYTE   4'h1
`define SFA_LAST_BIT   3'h7

`define SFA_CMD_UNLOCK 8'h06
`define SFA_CMD_LOCK   8'h04
`define SFA_CMD_RDSTAT 8'h05
`define SFA_CMD_WRSTAT 8'h01
`define SFA_CMD_READ   8'h03
`define SFA_CMD_PAGE   8'h02
`define SFA_CMD_BLOCK  8'hd8
`define SFA_CMD_FULL   8'hc7

`define SFA_SR_BUSY    0
`define SFA_SR_ARMED   1
`define SFA_SR_BP_LO   2
`define SFA_SR_BP_HI   4
`define SFA_SR_LOCK    7

`define SFA_REG_CTRL   12'h000
`define SFA_REG_STAT   12'h004
`define SFA_REG_LCMD   12'h008
`define SFA_REG_ADDR   12'h00c
`define SFA_CTRL_TOP   0

`define SFA_SZ_4K      19'h00fff
`define SFA_SZ_8K      19'h01fff
`define SFA_SZ_16K     19'h03fff
`define SFA_SZ_32K     19'h07fff
`define SFA_SZ_64K     19'h0ffff
`define SFA_BOT_S1     19'h01000
`define SFA_BOT_S2     19'h02000
`define SFA_BOT_S3     19'h04000
`define SFA_BOT_S4     19'h08000
`define SFA_BOT_S5     19'h10000
`define SFA_HALF       19'h40000
`define SFA_TOP_S7     19'h70000
`define SFA_TOP_S8     19'h78000
`define SFA_TOP_S9     19'h7c000
`define SFA_TOP_S10    19'h7e000
`define SFA_TOP_S11    19'h7f000

`endif

// >>> rtl/sfa_pkg.sv
// types shared by the serial flash device logic
// assumes sfa_map.svh is on the include path
`include "sfa_map.svh"
package sfa_pkg;

	typedef enum logic [2:0] {PH_IDLE, PH_CMD, PH_ADDR, PH_DIN, PH_STIN, PH_ROUT, PH_SOUT, PH_SKIP} sfa_phase_t;
	typedef enum logic [1:0] {OP_NONE, OP_PROG, OP_ERASE, OP_WSR} sfa_op_t;

	typedef struct packed {
		sfa_phase_t                  ph;
		logic [2:0]                  bits;
		logic [3:0]                  nb;
		logic [7:0]                  cmd;
		logic [7:0]                  shreg;
		logic [7:0]                  obyte;
		logic [2:0]                  ocnt;
		logic [7:0]                  sr_new;
		logic [7:0]                  last_cmd;
		logic [`SFA_ADDR_W-1:0]      addr;
		logic [`SFA_ADDR_W-1:0]      op_cnt;
		logic [`SFA_ADDR_W-1:0]      op_last;
		sfa_op_t                     op;
		logic                        cs_ok;
		logic                        armed;
		logic                        lock;
		logic [2:0]                  bp;
		logic                        top_boot;
		logic                        so;
		logic                        so_oe;
		logic                        pready;
		logic                        pslverr;
		logic [31:0]                 prdata;
		logic [`SFA_PAGE_BYTES-1:0]  wvalid;
	} sfa_state_t;

endpackage

// >>> rtl/sfa_pin_sync.sv
// two-flop synchroniser for the serial pins, with edge pulses after the second flop
// assumes raw inputs are asynchronous to pclk
`timescale 1ns/10ps
`default_nettype none
module sfa_pin_sync #(
	parameter int W = 5
) (
	input  wire logic         pclk,     // system clock
	input  wire logic         presetn,  // async reset, active low
	input  wire logic [W-1:0] raw,      // pins from the link
	output logic      [W-1:0] lvl,      // synchronised level
	output logic      [W-1:0] rise,     // one-cycle rising pulse
	output logic      [W-1:0] fall      // one-cycle falling pulse
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] prev_reg;

	generate
		if (W < 1) begin : g_bad
			$error("sfa_pin_sync needs W >= 1");
		end
	endgenerate

	// first flop feeds only the second one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= '0;
			lvl      <= '0;
			prev_reg <= '0;
		end else begin
			meta_reg <= raw;
			lvl      <= meta_reg;
			prev_reg <= lvl;
		end
	end

	assign rise = lvl & ~prev_reg;
	assign fall = ~lvl & prev_reg;
endmodule
`default_nettype wire

// >>> rtl/sfa_flash_dev.sv
// serial flash device: link command decoder, array, page buffer, internal cycles, apb registers
// assumes sclk well below pclk/4; link pins asynchronous to pclk
`timescale 1ns/10ps
`default_nettype none
`include "sfa_map.svh"
module sfa_flash_dev #(
	parameter int WSR_CYCLES = 64
) (
	input  wire logic        pclk,            // system clock, 40 MHz
	input  wire logic        presetn,         // async reset, active low
	input  wire logic        psel,            // apb select
	input  wire logic        penable,         // apb access phase
	input  wire logic        pwrite,          // apb direction
	input  wire logic [11:0] paddr,           // apb byte address
	input  wire logic [31:0] pwdata,          // apb write data
	output logic      [31:0] prdata,          // apb read data
	output logic             pready,          // apb ready
	output logic             pslverr,         // apb error on unmapped address
	input  wire logic        sclk_pin,        // serial clock from the master
	input  wire logic        sel_n_pin,       // select, active low
	input  wire logic        pause_n_pin,     // pause, active low
	input  wire logic        guard_n_pin,     // write guard, active low
	input  wire logic        serial_in_pin,   // serial data in
	output logic             serial_out_pin,  // serial data out
	output logic             serial_out_oe    // high while driving serial_out_pin
);
	import sfa_pkg::*;

	sfa_state_t st;
	sfa_state_t n;

	logic [7:0] mem [0:(1 << `SFA_ADDR_W)-1];
	logic [7:0] pbuf [0:`SFA_PAGE_BYTES-1];

	logic                   mem_we;
	logic [`SFA_ADDR_W-1:0] mem_wa;
	logic [7:0]             mem_wd;
	logic                   buf_we;
	logic [7:0]             buf_wa;
	logic [7:0]             buf_wd;
	logic [4:0]             s_lvl;
	logic [4:0]             s_rise;
	logic [4:0]             s_fall;

	wire logic sck_rise = s_rise[0];
	wire logic sck_fall = s_fall[0];
	wire logic cs_lvl   = s_lvl[1];
	wire logic cs_fall  = s_fall[1];
	wire logic cs_rise  = s_rise[1];
	wire logic pause_lv = s_lvl[2];
	wire logic guard_lv = s_lvl[3];
	wire logic di_lv    = s_lvl[4];
	wire logic run      = !cs_lvl && pause_lv;

	generate
		if (WSR_CYCLES < 1 || WSR_CYCLES > (1 << `SFA_ADDR_W)) begin : g_bad
			$error("sfa_flash_dev: WSR_CYCLES out of range");
		end
	endgenerate

	sfa_pin_sync #(
		.W(5)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.raw     ({serial_in_pin, guard_n_pin, pause_n_pin, sel_n_pin, sclk_pin}),
		.lvl     (s_lvl),
		.rise    (s_rise),
		.fall    (s_fall)
	);

	function automatic logic [7:0] stat_byte(input sfa_state_t s);
		logic [7:0] b;
		b = '0;
		b[`SFA_SR_BUSY]                 = (s.op != OP_NONE);
		b[`SFA_SR_ARMED]                = s.armed;
		b[`SFA_SR_BP_HI:`SFA_SR_BP_LO]  = s.bp;
		b[`SFA_SR_LOCK]                 = s.lock;
		return b;
	endfunction

	// size-1 of the sector holding a, for either boot placement
	function automatic logic [`SFA_ADDR_W-1:0] sec_mask(input logic [`SFA_ADDR_W-1:0] a, input logic top);
		if (top) begin
			if (a >= `SFA_TOP_S10)      return `SFA_SZ_4K;
			else if (a >= `SFA_TOP_S9)  return `SFA_SZ_8K;
			else if (a >= `SFA_TOP_S8)  return `SFA_SZ_16K;
			else if (a >= `SFA_TOP_S7)  return `SFA_SZ_32K;
			else                        return `SFA_SZ_64K;
		end else begin
			if (a < `SFA_BOT_S2)        return `SFA_SZ_4K;
			else if (a < `SFA_BOT_S3)   return `SFA_SZ_8K;
			else if (a < `SFA_BOT_S4)   return `SFA_SZ_16K;
			else if (a < `SFA_BOT_S5)   return `SFA_SZ_32K;
			else                        return `SFA_SZ_64K;
		end
	endfunction

	// protected area grows from the boot end as the range code rises
	function automatic logic prot_hit(input logic [`SFA_ADDR_W-1:0] a, input logic [2:0] bp, input logic top);
		if (top) begin
			case (bp)
				3'h1:    return a >= `SFA_TOP_S11;
				3'h2:    return a >= `SFA_TOP_S10;
				3'h3:    return a >= `SFA_TOP_S9;
				3'h4:    return a >= `SFA_TOP_S8;
				3'h5:    return a >= `SFA_TOP_S7;
				3'h6:    return a >= `SFA_HALF;
				3'h7:    return 1'b1;
				default: return 1'b0;
			endcase
		end else begin
			case (bp)
				3'h1:    return a < `SFA_BOT_S1;
				3'h2:    return a < `SFA_BOT_S2;
				3'h3:    return a < `SFA_BOT_S3;
				3'h4:    return a < `SFA_BOT_S4;
				3'h5:    return a < `SFA_BOT_S5;
				3'h6:    return a < `SFA_HALF;
				3'h7:    return 1'b1;
				default: return 1'b0;
			endcase
		end
	endfunction

	always_comb begin
		logic [7:0]             b;
		logic [`SFA_ADDR_W-1:0] a;
		logic [`SFA_ADDR_W-1:0] m;
		logic                   busy;
		b      = '0;
		a      = '0;
		m      = '0;
		busy   = (st.op != OP_NONE);
		n      = st;
		mem_we = 1'b0;
		mem_wa = st.op_cnt;
		mem_wd = `SFA_ERASED;
		buf_we = 1'b0;
		buf_wa = st.addr[7:0];
		buf_wd = '0;

		// apb: data is registered on the same edge as pready, writes land on the completing edge
		n.pready = psel && penable && !st.pready;
		if (psel && penable && !st.pready) begin
			n.pslverr = 1'b0;
			case (paddr)
				`SFA_REG_CTRL: n.prdata = {31'h0, st.top_boot};
				`SFA_REG_STAT: n.prdata = {24'h0, stat_byte(st)};
				`SFA_REG_LCMD: n.prdata = {24'h0, st.last_cmd};
				`SFA_REG_ADDR: n.prdata = {13'h0, st.addr};
				default: begin
					n.prdata  = '0;
					n.pslverr = 1'b1;
				end
			endcase
		end
		if (psel && penable && st.pready && pwrite && paddr == `SFA_REG_CTRL)
			n.top_boot = pwdata[`SFA_CTRL_TOP];

		// internal cycle walks op_cnt to op_last whatever select does
		if (busy) begin
			if (st.op == OP_PROG) begin
				mem_we = st.wvalid[st.op_cnt[7:0]];
				mem_wd = mem[st.op_cnt] & pbuf[st.op_cnt[7:0]];
			end else if (st.op == OP_ERASE) begin
				mem_we = 1'b1;
			end
			n.op_cnt = st.op_cnt + 1'b1;
			if (st.op_cnt == st.op_last) begin
				if (st.op == OP_WSR && !(st.lock && !guard_lv)) begin
					n.bp   = st.sr_new[`SFA_SR_BP_HI:`SFA_SR_BP_LO];
					n.lock = st.sr_new[`SFA_SR_LOCK];
				end
				n.op    = OP_NONE;
				n.armed = 1'b0;
			end
		end

		if (cs_lvl)
			n.cs_ok = 1'b1;

		if (cs_fall && st.cs_ok) begin
			n.ph   = PH_CMD;
			n.bits = '0;
			n.nb   = '0;
		end else if (cs_rise && st.ph != PH_IDLE) begin
			n.ph = PH_IDLE;
			// partial bytes cancel every modifying command
			if (st.bits == '0 && !busy) begin
				case (st.cmd)
					`SFA_CMD_UNLOCK: if (st.nb == `SFA_ONE_BYTE) n.armed = 1'b1;
					`SFA_CMD_LOCK:   if (st.nb == `SFA_ONE_BYTE) n.armed = 1'b0;
					`SFA_CMD_WRSTAT: begin
						if (st.nb == `SFA_SRW_BYTES && st.armed && !(st.lock && !guard_lv)) begin
							n.op      = OP_WSR;
							n.op_cnt  = '0;
							n.op_last = `SFA_ADDR_W'(WSR_CYCLES - 1);
						end
					end
					`SFA_CMD_PAGE: begin
						if (st.nb >= `SFA_PROG_MIN && st.armed && !prot_hit(st.addr, st.bp, st.top_boot)) begin
							n.op      = OP_PROG;
							n.op_cnt  = st.addr & ~`SFA_PAGE_MASK;
							n.op_last = st.addr | `SFA_PAGE_MASK;
						end
					end
					`SFA_CMD_BLOCK: begin
						m = sec_mask(st.addr, st.top_boot);
						if (st.nb == `SFA_ADDR_BYTES && st.armed && !prot_hit(st.addr & ~m, st.bp, st.top_boot)
						    && !prot_hit(st.addr | m, st.bp, st.top_boot)) begin
							n.op      = OP_ERASE;
							n.op_cnt  = st.addr & ~m;
							n.op_last = st.addr | m;
						end
					end
					`SFA_CMD_FULL: begin
						if (st.nb == `SFA_ONE_BYTE && st.armed && st.bp == '0) begin
							n.op      = OP_ERASE;
							n.op_cnt  = '0;
							n.op_last = `SFA_LAST_ADDR;
						end
					end
					default: ;
				endcase
			end
		end else if (run && sck_rise && st.ph != PH_IDLE) begin
			b       = {st.shreg[6:0], di_lv};
			n.shreg = b;
			n.bits  = st.bits + 1'b1;
			if (st.bits == `SFA_LAST_BIT) begin
				if (st.nb != '1)
					n.nb = st.nb + 1'b1;
				case (st.ph)
					PH_CMD: begin
						n.cmd      = b;
						n.last_cmd = b;
						if (busy && b != `SFA_CMD_RDSTAT) begin
							n.ph = PH_SKIP;
						end else begin
							case (b)
								`SFA_CMD_READ, `SFA_CMD_BLOCK: n.ph = PH_ADDR;
								`SFA_CMD_PAGE: begin
									n.ph     = PH_ADDR;
									n.wvalid = '0;
								end
								`SFA_CMD_WRSTAT: n.ph = PH_STIN;
								`SFA_CMD_RDSTAT: begin
									n.ph    = PH_SOUT;
									n.obyte = stat_byte(st);
									n.ocnt  = '0;
								end
								default: n.ph = PH_SKIP;
							endcase
						end
					end
					PH_ADDR: begin
						a      = {st.addr[10:0], b};
						n.addr = a;
						if (st.nb + 1'b1 == `SFA_ADDR_BYTES) begin
							case (st.cmd)
								`SFA_CMD_READ: begin
									n.ph    = PH_ROUT;
									n.obyte = mem[a];
									n.ocnt  = '0;
								end
								`SFA_CMD_PAGE: n.ph = PH_DIN;
								default:       n.ph = PH_SKIP;
							endcase
						end
					end
					PH_DIN: begin
						buf_we                  = 1'b1;
						buf_wd                  = b;
						n.wvalid[st.addr[7:0]]  = 1'b1;
						n.addr[7:0]             = st.addr[7:0] + 1'b1;
					end
					PH_STIN: begin
						n.sr_new = b;
						n.ph     = PH_SKIP;
					end
					default: ;
				endcase
			end
		end else if (run && sck_fall && (st.ph == PH_ROUT || st.ph == PH_SOUT)) begin
			n.so    = st.obyte[7];
			n.obyte = {st.obyte[6:0], 1'b0};
			n.ocnt  = st.ocnt + 1'b1;
			if (st.ocnt == `SFA_LAST_BIT) begin
				if (st.ph == PH_ROUT) begin
					n.addr  = st.addr + 1'b1;
					n.obyte = mem[st.addr + 1'b1];
				end else begin
					n.obyte = stat_byte(st);
				end
			end
		end

		n.so_oe = run && (n.ph == PH_ROUT || n.ph == PH_SOUT);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st          <= '0;
			st.ph       <= PH_IDLE;
			st.op       <= OP_NONE;
		end else begin
			st <= n;
		end
	end

	// array and page buffer carry no reset; contents are whatever the cells hold
	always_ff @(posedge pclk) begin
		if (mem_we)
			mem[mem_wa] <= mem_wd;
		if (buf_we)
			pbuf[buf_wa] <= buf_wd;
	end

	assign prdata         = st.prdata;
	assign pready         = st.pready;
	assign pslverr        = st.pslverr;
	assign serial_out_pin = st.so;
	assign serial_out_oe  = st.so_oe;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_out_deselected: assert property (cs_lvl |=> !serial_out_oe)
		else $error("output driven while deselected");
	chk_out_paused: assert property (!cs_lvl && !pause_lv |=> !serial_out_oe)
		else $error("output driven while paused");
	chk_out_falling: assert property ($changed(serial_out_pin) |-> $past(sck_fall && run))
		else $error("serial output moved off a falling edge");
	chk_in_rising: assert property (run && sck_rise && st.ph != PH_IDLE && !cs_fall && !cs_rise
		|=> st.shreg[0] == $past(di_lv) && st.bits == $past(st.bits) + 3'h1)
		else $error("input bit not captured on rising edge");
	chk_wait_select: assert property (!st.cs_ok |=> st.ph == PH_IDLE)
		else $error("command started before select went high");
	chk_armed_clear: assert property ($fell(st.op != OP_NONE) |-> !st.armed)
		else $error("armed flag survived a completed cycle");
	chk_cycle_runs: assert property ((st.op != OP_NONE) && st.op_cnt != st.op_last
		|=> st.op == $past(st.op) && st.op_cnt == $past(st.op_cnt) + 1'b1)
		else $error("internal cycle stopped early");
	chk_start_aligned: assert property ($rose(st.op != OP_NONE) |-> $past(cs_rise && st.bits == '0 && st.armed))
		else $error("cycle started without aligned armed command");
	// judged on the stored cell after the write, so a broken write path is caught
	chk_prog_clears: assert property (mem_we && st.op == OP_PROG
		|=> (mem[$past(mem_wa)] & ~$past(mem[mem_wa])) == '0)
		else $error("program set a bit to one");
	chk_lock_hold: assert property (st.lock && !guard_lv && !$changed(guard_lv)
		|=> st.bp == $past(st.bp) && st.lock)
		else $error("guarded status bits changed");
	chk_prog_page: assert property (st.op == OP_PROG |-> (st.op_last & ~`SFA_PAGE_MASK) == (st.op_cnt & ~`SFA_PAGE_MASK))
		else $error("program walk left its page");

	cov_read: cover property (st.ph == PH_ROUT && sck_fall && st.ocnt == `SFA_LAST_BIT);
	cov_prog: cover property ($rose(st.op == OP_PROG));
	cov_erase: cover property ($rose(st.op == OP_ERASE));
	cov_wsr_done: cover property ($fell(st.op == OP_WSR));
endmodule
`default_nettype wire

// >>> tb/sfa_spi_master.sv
// serial bus master model standing on the far side of the flash device link
// assumes the bench calls its tasks one at a time; sclk is still between frames
`timescale 1ns/10ps
`default_nettype none
module sfa_spi_master (
	output logic      sclk,     // serial clock
	output logic      sel_n,    // select, active low
	output logic      pause_n,  // pause, active low
	output logic      sdi,      // data towards the device
	input  wire logic sdo,      // data from the device
	input  wire logic sdo_oe,   // device drives sdo while high
	input  wire logic mode3     // clock idles high when set
);
	logic last_rx;
	logic rx_line;

	// a floating line shows the inverse of its last value, so stale data never passes
	assign rx_line = sdo_oe ? sdo : ~last_rx;

	initial begin
		sclk    = 1'b0;
		sel_n   = 1'b0; // low from power-up: the first frame must not count
		pause_n = 1'b1;
		sdi     = 1'b0;
		last_rx = 1'b0;
	end

	task automatic frame_start();
		#7;
		sclk = mode3; // idle level of mode 0 or mode 3
		#100;
		sel_n = 1'b0;
		#100;
	endtask

	// msb first; data set while low, taken by both sides on the rise
	task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 0; i < n; i++) begin
			sclk = 1'b0;
			sdi  = tx[7-i];
			#100;
			sclk    = 1'b1;
			rx[7-i] = rx_line;
			last_rx = rx_line;
			#100;
		end
	endtask

	task automatic frame_end();
		#100;
		sclk = mode3;
		#100;
		sel_n = 1'b1;
		sdi   = ~sdi;
		#400;
	endtask

	// clock and data wiggle while paused; reports whether the device drove meanwhile
	task automatic pause_noise(output logic oe_seen);
		oe_seen = 1'b0;
		pause_n = 1'b0;
		#100;
		repeat (8) begin
			sclk = ~sclk;
			sdi  = ~sdi;
			#100;
			oe_seen = oe_seen | sdo_oe;
		end
		pause_n = 1'b1;
		#100;
	endtask
endmodule
`default_nettype wire

// >>> tb/sfa_tb.sv
// self-checking bench for the serial flash device: apb registers plus link traffic
// assumes the master model drives the link and WSR_CYCLES is shortened to 4
`timescale 1ns/10ps
`default_nettype none
`include "sfa_map.svh"
module testbench;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        sclk;
	logic        sel_n;
	logic        pause_n;
	logic        guard_n;
	logic        sdi;
	logic        sdo;
	logic        sdo_oe;
	logic        mode3;
	logic [7:0]  rx;
	logic [7:0]  s;
	logic [31:0] v;
	logic        e;
	logic        oe_seen;
	int          took;
	int          n_fail  = 0;
	int          n_tests = 0;
	int          cyc     = 0;

	sfa_flash_dev #(.WSR_CYCLES(4)) sfa_flash_dev_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sclk_pin(sclk), .sel_n_pin(sel_n), .pause_n_pin(pause_n),
		.guard_n_pin(guard_n), .serial_in_pin(sdi), .serial_out_pin(sdo), .serial_out_oe(sdo_oe));
	sfa_spi_master sfa_spi_master_inst (.sclk(sclk), .sel_n(sel_n), .pause_n(pause_n), .sdi(sdi),
		.sdo(sdo), .sdo_oe(sdo_oe), .mode3(mode3));

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	task automatic finish_test();
		if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	always @(posedge pclk) begin
		cyc = cyc + 1;
		if (cyc == 90000) begin
			n_fail = n_fail + 1;
			finish_test();
		end
	end

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", nm, exp, got);
			n_fail++;
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		e  = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) chk("pready", 1, 0);
	endtask

	task automatic wait_idle();
		int t0;
		logic [31:0] st;
		t0 = cyc;
		st = 1;
		while (st[0] !== 1'b0 && cyc - t0 < 20000) apb(0, `SFA_REG_STAT, 0, st);
		took = cyc - t0;
		chk("busy timeout", 0, st[0]);
	endtask

	task automatic fs();
		sfa_spi_master_inst.frame_start();
	endtask
	task automatic fe();
		sfa_spi_master_inst.frame_end();
	endtask
	task automatic sh(input logic [7:0] tx, input int n);
		sfa_spi_master_inst.shift(tx, n, rx);
	endtask
	task automatic cmd(input logic [7:0] op);
		fs();
		sh(op, 8);
		fe();
	endtask
	task automatic hdr(input logic [7:0] op, input logic [23:0] a);
		fs();
		sh(op, 8);
		sh(a[23:16], 8);
		sh(a[15:8], 8);
		sh(a[7:0], 8);
	endtask
	task automatic rd_status();
		fs();
		sh(`SFA_CMD_RDSTAT, 8);
		sh(8'h00, 8);
		s = rx;
		fe();
	endtask
	task automatic fread(input logic [23:0] a, input logic [23:0] exp);
		hdr(`SFA_CMD_READ, a);
		for (int i = 0; i < 3; i++) begin
			sh(8'h00, 8);
			chk("read byte", exp[23-8*i -: 8], rx);
		end
		fe();
	endtask
	task automatic prog(input logic [23:0] a, input logic [15:0] d, input int nb, input logic bexp);
		cmd(`SFA_CMD_UNLOCK);
		hdr(`SFA_CMD_PAGE, a);
		sh(d[15:8], 8);
		sh(d[7:0], nb);
		apb(0, `SFA_REG_STAT, 0, v);
		chk("busy while selected", 0, v[0]);
		fe();
		apb(0, `SFA_REG_STAT, 0, v);
		chk("busy after select", bexp, v[0]);
		wait_idle();
	endtask
	task automatic wipe(input logic [23:0] a, input int lo, input int hi);
		cmd(`SFA_CMD_UNLOCK);
		hdr(`SFA_CMD_BLOCK, a);
		fe();
		wait_idle();
		chk("wipe duration", 1, took >= lo && took <= hi);
	endtask
	task automatic wsr(input logic [7:0] d);
		cmd(`SFA_CMD_UNLOCK);
		fs();
		sh(`SFA_CMD_WRSTAT, 8);
		sh(d, 8);
		fe();
		wait_idle();
	endtask

	task automatic t_powerup();
		sh(`SFA_CMD_UNLOCK, 8);
		fe();
		apb(0, `SFA_REG_STAT, 0, v);
		chk("armed before first select", 0, v[`SFA_SR_ARMED]);
		chk("oe deselected", 0, sdo_oe);
		apb(0, `SFA_REG_CTRL, 0, v);
		chk("ctrl reset", 0, v);
		apb(0, 12'h010, 0, v);
		chk("unmapped error", 1, e);
	endtask

	task automatic t_modes();
		@(posedge pclk) mode3 <= 1'b1;
		cmd(`SFA_CMD_UNLOCK);
		rd_status();
		chk("status armed mode 3", 8'h02, s);
		@(posedge pclk) mode3 <= 1'b0;
		cmd(`SFA_CMD_LOCK);
		rd_status();
		chk("status after lock", 8'h00, s);
	endtask

	task automatic t_array();
		wipe(24'h000100, 4000, 6000);
		wipe(24'h002000, 8000, 10000);
		fread(24'h0000fd, 24'hffffff);
		prog(24'h0000ff, 16'h3c5a, 8, 1'b1);
		rd_status();
		chk("armed after program", 8'h00, s);
		fread(24'h0000fe, 24'hff3cff);
		fread(24'h000000, 24'h5affff);
		prog(24'h000000, 16'hf00f, 8, 1'b1);
		fread(24'h000000, 24'h500fff);
		prog(24'h000002, 16'h0000, 7, 1'b0);
		fread(24'h000001, 24'h0fffff);
		apb(0, `SFA_REG_LCMD, 0, v);
		chk("last command", `SFA_CMD_READ, v);
		apb(0, `SFA_REG_ADDR, 0, v);
		chk("address after read", 32'h4, v);
	endtask

	task automatic t_pause();
		hdr(`SFA_CMD_READ, 24'h000000);
		sh(8'h00, 8);
		chk("byte before pause", 8'h50, rx);
		sfa_spi_master_inst.pause_noise(oe_seen);
		chk("oe while paused", 0, oe_seen);
		sh(8'h00, 8);
		chk("byte after pause", 8'h0f, rx);
		fe();
		chk("oe after deselect", 0, sdo_oe);
	endtask

	task automatic t_protect();
		wsr(8'h84);
		rd_status();
		chk("status written", 8'h84, s);
		prog(24'h000010, 16'h0000, 8, 1'b0);
		fread(24'h000010, 24'hffffff);
		cmd(`SFA_CMD_UNLOCK);
		cmd(`SFA_CMD_FULL);
		apb(0, `SFA_REG_STAT, 0, v);
		chk("full wipe refused", 0, v[0]);
		@(posedge pclk) guard_n <= 1'b0;
		wsr(8'h00);
		rd_status();
		chk("locked status", 8'h84, s & 8'hfd);
		@(posedge pclk) guard_n <= 1'b1;
		wsr(8'h00);
		rd_status();
		chk("unlocked status", 8'h00, s);
	endtask

	task automatic t_top();
		apb(1, `SFA_REG_CTRL, 32'h1, v);
		apb(0, `SFA_REG_CTRL, 0, v);
		chk("ctrl top boot", 32'h1, v);
		wipe(24'h07f000, 4000, 6000);
		fread(24'h07fffd, 24'hffffff);
	endtask

	initial begin
		presetn = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 12'h000;
		pwdata  = 32'h0;
		guard_n = 1'b1;
		mode3   = 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_powerup();
		t_modes();
		t_array();
		t_pause();
		t_protect();
		t_top();
		finish_test();
	end
endmodule
`default_nettype wire
